// ===== include/dicr_defs.svh
// Offsets, field positions, reset values and counts of the converter config register bank.
// Assumes an 8-bit register port with byte-wide offsets.
`ifndef DICR_DEFS_SVH
`define DICR_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define DICR_OFS_MODE      8'h01
`define DICR_OFS_FORMAT    8'h02
`define DICR_OFS_FILTER    8'h03
`define DICR_OFS_PLL       8'h04
`define DICR_OFS_REVISION  8'h0d
`define DICR_OFS_CALCLK    8'h0e
`define DICR_OFS_MEMCTL    8'h0f
`define DICR_OFS_MEMLOC    8'h10

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define DICR_RST_REG       8'h00
`define DICR_REVISION_ID   4'h5

// ----------------------------------------------------------------
// Mode register fields
// ----------------------------------------------------------------
`define DICR_MODE_EXTLOCK  0
`define DICR_MODE_SINGLE   1

// ----------------------------------------------------------------
// Input format and clock fields
// ----------------------------------------------------------------
`define DICR_FMT_UNSIGNED  7
`define DICR_FMT_SINGLE_PORT_INTERLEAVE   6
`define DICR_FMT_DRIVE     5
`define DICR_FMT_DLLEN     4
`define DICR_FMT_DIR       3

// ----------------------------------------------------------------
// Filter mode fields
// ----------------------------------------------------------------
`define DICR_FLT_CHANNEL   7
`define DICR_FLT_REAL_IMAG_OUTPUT_SELECT  6
`define DICR_FLT_HILBERT   5
`define DICR_FLT_HP8       4
`define DICR_FLT_HP4       3
`define DICR_FLT_HP2       2
`define DICR_FLT_CLKPOL    1
`define DICR_FLT_IQ_ORDER_POLARITY     0

// ----------------------------------------------------------------
// PLL fields
// ----------------------------------------------------------------
`define DICR_PLL_ON        7
`define DICR_PLL_MULT_LO   5
`define DICR_PLL_DIV_LO    3

// ----------------------------------------------------------------
// Calibration clock and memory control fields
// ----------------------------------------------------------------
`define DICR_CK_FUSE       7
`define DICR_CK_FUSE_WRITE_REQUEST     6
`define DICR_CK_SRC_LO     4
`define DICR_MC_CALSTAT    7
`define DICR_MC_CALIBRATION_RUN      6
`define DICR_MC_XSTAT      5
`define DICR_MC_XEN        4
`define DICR_MC_SWR        3
`define DICR_MC_SRD        2
`define DICR_MC_FRD        1
`define DICR_MC_BYPASS_CALIBRATION      0

// ----------------------------------------------------------------
// Calibration clock divider: code 0 divides by 2**5
// ----------------------------------------------------------------
`define DICR_CALDIV_BASE   4'd5
`define DICR_CALCNT_W      12

`endif

// ===== include/dicr_pkg.sv
// Types shared by the converter config register bank and its memory sequencer.
// Assumes dicr_defs.svh supplies all numeric constants.
package dicr_pkg;

  // Converter source routing
  typedef enum logic [1:0] {
    DICR_SRC_I    = 2'b00,
    DICR_SRC_Q    = 2'b01,
    DICR_SRC_REAL = 2'b10,
    DICR_SRC_IMAG = 2'b11
  } dicr_dac_src_t;

  // Memory operation index, priority order low index first
  typedef enum logic [1:0] {
    DICR_OP_FUSE_WR = 2'b00,
    DICR_OP_SMEM_WR = 2'b01,
    DICR_OP_SMEM_RD = 2'b10,
    DICR_OP_FUSE_RD = 2'b11
  } dicr_mem_op_t;

  // Memory sequencer state
  typedef enum logic [0:0] {
    DICR_SEQ_IDLE = 1'b0,
    DICR_SEQ_BUSY = 1'b1
  } dicr_seq_state_t;

endpackage

// ===== core/dicr_mem_sequencer.sv
// Calibration clock divider and one-at-a-time memory operation sequencer.
// Assumes dataRateTick and memAck are already on clk; requests are held until done.
`timescale 1ns/10ps
`include "dicr_defs.svh"

module dicr_mem_sequencer (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Calibration clock
  input wire logic calRun,
  input wire logic [2:0] calDivide,
  input wire logic dataRateTick,
  output logic calClock_q,
  // Memory operations
  input wire logic [3:0] opPending,
  input wire logic memAck,
  output logic [3:0] opStrobe_q,
  output logic [3:0] opDone_q
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [`DICR_CALCNT_W-1:0] halfPeriod(input logic [2:0] code);
    logic [3:0] shiftAmt;
    shiftAmt = `DICR_CALDIV_BASE + {1'b0, code} - 4'd1;
    halfPeriod = `DICR_CALCNT_W'(1) << shiftAmt;
  endfunction

  function automatic logic [3:0] firstOne(input logic [3:0] req);
    logic [3:0] pick;
    pick = 4'h0;
    for (int i = 3; i >= 0; i--) begin
      if (req[i]) begin
        pick = 4'h0;
        pick[i] = 1'b1;
      end
    end
    firstOne = pick;
  endfunction

  // ----------------------------------------------------------------
  // Calibration clock
  // ----------------------------------------------------------------
  logic [`DICR_CALCNT_W-1:0] calCount_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      calCount_q <= '0;
      calClock_q <= 1'b0;
    end else if (!calRun) begin
      calCount_q <= '0;
      calClock_q <= 1'b0;
    end else if (dataRateTick) begin
      if (calCount_q == halfPeriod(calDivide) - `DICR_CALCNT_W'(1)) begin
        calCount_q <= '0;
        calClock_q <= ~calClock_q;
      end else begin
        calCount_q <= calCount_q + `DICR_CALCNT_W'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // Memory operations
  // ----------------------------------------------------------------
  dicr_pkg::dicr_seq_state_t state_q;
  logic [3:0] active_q;
  logic memAckLast_q;
  logic memAckRise;

  // Only a fresh ack ends an op; a long ack must not also end the next one
  assign memAckRise = memAck && !memAckLast_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      memAckLast_q <= 1'b0;
    end else begin
      memAckLast_q <= memAck;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= dicr_pkg::DICR_SEQ_IDLE;
      active_q <= 4'h0;
      opStrobe_q <= 4'h0;
      opDone_q <= 4'h0;
    end else begin
      opStrobe_q <= 4'h0;
      opDone_q <= 4'h0;
      case (state_q)
        dicr_pkg::DICR_SEQ_IDLE: begin
          // Pending bit drops one cycle after done; do not issue it twice
          if (|(opPending & ~opDone_q)) begin
            active_q <= firstOne(opPending & ~opDone_q);
            opStrobe_q <= firstOne(opPending & ~opDone_q);
            state_q <= dicr_pkg::DICR_SEQ_BUSY;
          end
        end
        dicr_pkg::DICR_SEQ_BUSY: begin
          if (memAckRise) begin
            opDone_q <= active_q;
            active_q <= 4'h0;
            state_q <= dicr_pkg::DICR_SEQ_IDLE;
          end
        end
        default: begin
          state_q <= dicr_pkg::DICR_SEQ_IDLE;
        end
      endcase
    end
  end

endmodule

// ===== core/dicr_regs.sv
// Control and status register bank of the interpolating converter.
// Assumes a same-clock register port; status pins arrive from other domains.
`timescale 1ns/10ps
`include "dicr_defs.svh"

module dicr_regs (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  output logic [7:0] regRdData_q,
  // Status pins from analog and DLL
  input wire logic [2:0] dllFlagsPin,
  input wire logic masterFusePin,
  input wire logic calDonePin,
  input wire logic xferDonePin,
  input wire logic memAckPin,
  // Data rate strobe from the data path
  input wire logic dataRateTick,
  // Data path controls
  output logic unsignedInput_q,
  output logic singlePortInterleave_q,
  output logic ifaceClkDrive24mA_q,
  output logic ifaceClkDllOn_q,
  output logic ifaceClkOe_n_q,
  output logic ifaceClkPolarity_q,
  output logic iqOrderPolarity_q,
  output dicr_pkg::dicr_dac_src_t dacSource_q,
  output logic hilbertOn_q,
  output logic [2:0] stageHighpass_q,
  // Clock multiplier
  output logic clock_multiplier_enable_q,
  output logic [1:0] pllMultiply_q,
  output logic [1:0] pllDivide_q,
  // Calibration and memory
  output logic calRunning_q,
  output logic calClock_q,
  output logic xferRunning_q,
  output logic bypassCal_q,
  output logic [7:0] memLocation_q,
  output logic [3:0] memOpStrobe_q
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // ----------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------
  logic [6:0] pinMeta_q;
  logic [6:0] pinSync_q;
  logic [2:0] dllFlags;
  logic masterFuse;
  logic calDone;
  logic xferDone;
  logic memAck;

  // Pins change freely; two stages before any use
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pinMeta_q <= 7'h00;
      pinSync_q <= 7'h00;
    end else begin
      pinMeta_q <= {memAckPin, xferDonePin, calDonePin, masterFusePin, dllFlagsPin};
      pinSync_q <= pinMeta_q;
    end
  end

  assign dllFlags = pinSync_q[2:0];
  assign masterFuse = pinSync_q[3];
  assign calDone = pinSync_q[4];
  assign xferDone = pinSync_q[5];
  assign memAck = pinSync_q[6];

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  logic wrMode;
  logic wrFormat;
  logic wrFilter;
  logic wrPll;
  logic wrCalClk;
  logic wrMemCtl;
  logic wrMemLoc;

  assign wrMode = regWrStb && hit(regAddr, `DICR_OFS_MODE);
  assign wrFormat = regWrStb && hit(regAddr, `DICR_OFS_FORMAT);
  assign wrFilter = regWrStb && hit(regAddr, `DICR_OFS_FILTER);
  assign wrPll = regWrStb && hit(regAddr, `DICR_OFS_PLL);
  assign wrCalClk = regWrStb && hit(regAddr, `DICR_OFS_CALCLK);
  assign wrMemCtl = regWrStb && hit(regAddr, `DICR_OFS_MEMCTL);
  assign wrMemLoc = regWrStb && hit(regAddr, `DICR_OFS_MEMLOC);

  // ----------------------------------------------------------------
  // Plain configuration registers
  // ----------------------------------------------------------------
  logic [1:0] mode_q;
  logic [7:3] format_q;
  logic [7:0] filter_q;
  logic [7:0] pll_q;
  logic [2:0] calDivide_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= 2'b00;
      format_q <= 5'h00;
      filter_q <= `DICR_RST_REG;
      pll_q <= `DICR_RST_REG;
      calDivide_q <= 3'h0;
      memLocation_q <= `DICR_RST_REG;
    end else begin
      if (wrMode) begin
        mode_q <= regWrData[1:0];
      end
      if (wrFormat) begin
        format_q <= regWrData[7:3];
      end
      if (wrFilter) begin
        filter_q <= regWrData;
      end
      if (wrPll) begin
        pll_q <= regWrData;
      end
      if (wrCalClk) begin
        calDivide_q <= regWrData[2:0];
      end
      if (wrMemLoc) begin
        memLocation_q <= regWrData;
      end
    end
  end

  // ----------------------------------------------------------------
  // Memory control and status
  // ----------------------------------------------------------------
  logic calRun_q;
  logic calStat_q;
  logic xferRun_q;
  logic fuse_transfer_done_q;
  logic bypass_q;
  logic [3:0] opPend_q;
  logic [3:0] opDone;
  logic [3:0] opWrite;
  logic calStart;
  logic xferStart;

  // Op bits: fuse write, static write, static read, fuse read
  assign opWrite[0] = wrCalClk && regWrData[`DICR_CK_FUSE_WRITE_REQUEST];
  assign opWrite[1] = wrMemCtl && regWrData[`DICR_MC_SWR];
  assign opWrite[2] = wrMemCtl && regWrData[`DICR_MC_SRD];
  assign opWrite[3] = wrMemCtl && regWrData[`DICR_MC_FRD];
  assign calStart = wrMemCtl && regWrData[`DICR_MC_CALIBRATION_RUN];
  assign xferStart = wrMemCtl && regWrData[`DICR_MC_XEN];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      calRun_q <= 1'b0;
    end else if (calStart) begin
      calRun_q <= 1'b1;
    end else if (wrMemCtl) begin
      calRun_q <= 1'b0;
    end else if (calDone) begin
      calRun_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      calStat_q <= 1'b0;
    end else if (calRun_q && calDone) begin
      calStat_q <= 1'b1;
    end else if (calStart) begin
      calStat_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      xferRun_q <= 1'b0;
    end else if (xferStart) begin
      xferRun_q <= 1'b1;
    end else if (wrMemCtl) begin
      xferRun_q <= 1'b0;
    end else if (xferDone) begin
      xferRun_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fuse_transfer_done_q <= 1'b0;
    end else if (xferRun_q && xferDone) begin
      fuse_transfer_done_q <= 1'b1;
    end else if (xferStart) begin
      fuse_transfer_done_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bypass_q <= 1'b0;
    end else if (wrMemCtl) begin
      bypass_q <= regWrData[`DICR_MC_BYPASS_CALIBRATION];
    end
  end

  // Requests held until done; a new write wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      opPend_q <= 4'h0;
    end else begin
      opPend_q <= (opPend_q & ~opDone) | opWrite;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  logic calClockRaw;
  logic [3:0] opStrobeRaw;

  dicr_mem_sequencer uSeq (
    .clk(clk),
    .rst_n(rst_n),
    .calRun(calRun_q),
    .calDivide(calDivide_q),
    .dataRateTick(dataRateTick),
    .calClock_q(calClockRaw),
    .opPending(opPend_q),
    .memAck(memAck),
    .opStrobe_q(opStrobeRaw),
    .opDone_q(opDone)
  );

  // ----------------------------------------------------------------
  // Data path controls
  // ----------------------------------------------------------------
  logic singleMode;
  logic extLock;

  assign singleMode = mode_q[`DICR_MODE_SINGLE];
  assign extLock = mode_q[`DICR_MODE_EXTLOCK];

  // Registered so every control leaves on a flop
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      unsignedInput_q <= 1'b0;
      singlePortInterleave_q <= 1'b0;
      ifaceClkDrive24mA_q <= 1'b0;
      ifaceClkDllOn_q <= 1'b0;
      ifaceClkOe_n_q <= 1'b1;
      ifaceClkPolarity_q <= 1'b0;
      iqOrderPolarity_q <= 1'b0;
      dacSource_q <= dicr_pkg::DICR_SRC_I;
      hilbertOn_q <= 1'b0;
      stageHighpass_q <= 3'h0;
    end else begin
      unsignedInput_q <= format_q[`DICR_FMT_UNSIGNED];
      singlePortInterleave_q <= format_q[`DICR_FMT_SINGLE_PORT_INTERLEAVE];
      ifaceClkDrive24mA_q <= format_q[`DICR_FMT_DRIVE];
      ifaceClkDllOn_q <= format_q[`DICR_FMT_DLLEN] && !extLock && !format_q[`DICR_FMT_DIR];
      ifaceClkOe_n_q <= !(format_q[`DICR_FMT_DIR] && !extLock);
      ifaceClkPolarity_q <= filter_q[`DICR_FLT_CLKPOL];
      iqOrderPolarity_q <= filter_q[`DICR_FLT_IQ_ORDER_POLARITY];
      if (singleMode) begin
        dacSource_q <= filter_q[`DICR_FLT_REAL_IMAG_OUTPUT_SELECT] ? dicr_pkg::DICR_SRC_IMAG
                                                    : dicr_pkg::DICR_SRC_REAL;
      end else begin
        dacSource_q <= filter_q[`DICR_FLT_CHANNEL] ? dicr_pkg::DICR_SRC_Q
                                                   : dicr_pkg::DICR_SRC_I;
      end
      hilbertOn_q <= singleMode && filter_q[`DICR_FLT_HILBERT];
      stageHighpass_q <= {filter_q[`DICR_FLT_HP8], filter_q[`DICR_FLT_HP4],
                          filter_q[`DICR_FLT_HP2]};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clock_multiplier_enable_q <= 1'b0;
      pllMultiply_q <= 2'b00;
      pllDivide_q <= 2'b00;
    end else begin
      clock_multiplier_enable_q <= pll_q[`DICR_PLL_ON];
      pllMultiply_q <= pll_q[`DICR_PLL_MULT_LO +: 2];
      pllDivide_q <= pll_q[`DICR_PLL_DIV_LO +: 2];
    end
  end

  // Calibration and memory controls
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      calRunning_q <= 1'b0;
      calClock_q <= 1'b0;
      xferRunning_q <= 1'b0;
      bypassCal_q <= 1'b0;
      memOpStrobe_q <= 4'h0;
    end else begin
      calRunning_q <= calRun_q;
      calClock_q <= calClockRaw;
      xferRunning_q <= xferRun_q;
      bypassCal_q <= bypass_q;
      memOpStrobe_q <= opStrobeRaw;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [7:0] rdMux;
  logic [2:0] dllFlagsShown;
  logic [1:0] calSource;

  // Flags mean nothing with the DLL off, so they read zero
  assign dllFlagsShown = ifaceClkDllOn_q ? dllFlags : 3'h0;
  // Uncalibrated when bypassed, else self calibration once a run has finished
  assign calSource = bypass_q ? 2'b00 : (calStat_q ? 2'b01 : 2'b00);

  always_comb begin
    rdMux = 8'h00;
    case (regAddr)
      `DICR_OFS_MODE: begin
        rdMux = {6'h00, mode_q};
      end
      `DICR_OFS_FORMAT: begin
        rdMux = {format_q, dllFlagsShown};
      end
      `DICR_OFS_FILTER: begin
        rdMux = filter_q;
      end
      `DICR_OFS_PLL: begin
        rdMux = pll_q;
      end
      `DICR_OFS_REVISION: begin
        rdMux = {4'h0, `DICR_REVISION_ID};
      end
      `DICR_OFS_CALCLK: begin
        rdMux = {masterFuse, opPend_q[0], calSource, 1'b0, calDivide_q};
      end
      `DICR_OFS_MEMCTL: begin
        rdMux = {calStat_q, calRun_q, fuse_transfer_done_q, xferRun_q,
                 opPend_q[1], opPend_q[2], opPend_q[3], bypass_q};
      end
      `DICR_OFS_MEMLOC: begin
        rdMux = memLocation_q;
      end
      default: begin
        rdMux = 8'h00;
      end
    endcase
  end

  // Data stands only in the cycle after the strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdData_q <= 8'h00;
    end else if (regRdStb) begin
      regRdData_q <= rdMux;
    end else begin
      regRdData_q <= 8'h00;
    end
  end

endmodule

// ===== tb/dicr_regs_chk.sv
// Port assertions for the converter config register bank.
// Assumes the bind at the foot attaches it to every dicr_regs.
`timescale 1ns/10ps
module dicr_regs_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  input wire logic [7:0] regRdData_q,
  // Watched controls
  input wire logic [2:0] stageHighpass_q,
  input wire logic clock_multiplier_enable_q,
  input wire logic [1:0] pllMultiply_q,
  input wire logic [1:0] pllDivide_q,
  input wire logic calRunning_q,
  input wire logic bypassCal_q,
  input wire logic [7:0] memLocation_q,
  input wire logic [3:0] memOpStrobe_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  rd_idle_zero_a: assert property (!$past(regRdStb) |-> regRdData_q == 8'h00)
    else $error("read data not zero outside read");
  stage_select_a: assert property (regWrStb && regAddr == 8'h03 |->
    ##2 stageHighpass_q == $past(regWrData[4:2], 2)) else $error("stage select wrong");
  pll_fields_a: assert property (regWrStb && regAddr == 8'h04 |->
    ##2 {clock_multiplier_enable_q, pllMultiply_q, pllDivide_q} == $past(regWrData[7:3], 2))
    else $error("pll fields wrong");
  mem_location_a: assert property (regWrStb && regAddr == 8'h10 |->
    ##2 memLocation_q == $past(regWrData, 2)) else $error("location wrong");
  bypass_bit_a: assert property (regWrStb && regAddr == 8'h0f |->
    ##2 bypassCal_q == $past(regWrData[0], 2)) else $error("bypass wrong");
  cal_start_a: assert property (regWrStb && regAddr == 8'h0f && regWrData[6] |->
    ##2 calRunning_q) else $error("calibration not started");
  strobe_onehot_a: assert property ($onehot0(memOpStrobe_q))
    else $error("several memory strobes");
  smem_write_lat_a: assert property (regWrStb && regAddr == 8'h0f && regWrData[3:0] == 4'h8 |->
    ##3 memOpStrobe_q == 4'h2) else $error("static write strobe late");
endmodule
bind dicr_regs dicr_regs_chk chkInst (.clk, .rst_n, .regAddr, .regWrData, .regWrStb,
  .regRdStb, .regRdData_q, .stageHighpass_q, .clock_multiplier_enable_q, .pllMultiply_q, .pllDivide_q,
  .calRunning_q, .bypassCal_q, .memLocation_q, .memOpStrobe_q);

// ===== tb/dicr_regs_tb.sv
// Self-checking bench for the converter config register bank.
// Assumes dicr_regs and its checker are compiled before it.
`timescale 1ns/10ps
`include "dicr_defs.svh"
module dicr_regs_tb;
  logic clk = 0, rst_n = 0, regWrStb = 0, regRdStb = 0, c;
  logic masterFusePin = 0, calDonePin = 0, xferDonePin = 0, memAckPin = 0, dataRateTick = 0;
  logic [7:0] regAddr = 0, regWrData = 0, regRdData_q, memLocation_q, rv;
  logic [2:0] dllFlagsPin = 0, stageHighpass_q;
  logic unsignedInput_q, singlePortInterleave_q, ifaceClkDrive24mA_q, ifaceClkDllOn_q;
  logic ifaceClkOe_n_q, ifaceClkPolarity_q, iqOrderPolarity_q, hilbertOn_q, clock_multiplier_enable_q;
  logic calRunning_q, calClock_q, xferRunning_q, bypassCal_q;
  logic [1:0] pllMultiply_q, pllDivide_q;
  logic [3:0] memOpStrobe_q;
  dicr_pkg::dicr_dac_src_t dacSource_q;
  logic [7:0] mdl [0:255];
  logic [7:0] ads [5] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h10};
  logic [7:0] rs [9] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h0d, 8'h0e, 8'h0f, 8'h10, 8'h20};
  int error_cnt = 0, checks_done = 0, cyc = 0, seed = 27053, n;

  dicr_regs dut (.clk, .rst_n, .regAddr, .regWrData, .regWrStb, .regRdStb, .regRdData_q,
    .dllFlagsPin, .masterFusePin, .calDonePin, .xferDonePin, .memAckPin, .dataRateTick,
    .unsignedInput_q, .singlePortInterleave_q, .ifaceClkDrive24mA_q, .ifaceClkDllOn_q,
    .ifaceClkOe_n_q, .ifaceClkPolarity_q, .iqOrderPolarity_q, .dacSource_q, .hilbertOn_q,
    .stageHighpass_q, .clock_multiplier_enable_q, .pllMultiply_q, .pllDivide_q, .calRunning_q, .calClock_q,
    .xferRunning_q, .bypassCal_q, .memLocation_q, .memOpStrobe_q);

  // ----------------------------------------------------------------
  // Clock, watchdog and shared tasks
  // ----------------------------------------------------------------
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      finish_test;
    end
  end
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'b1;
    @(posedge clk);
    regWrStb <= 1'b0;
    if (a < 8'h05 || a == 8'h10) mdl[a] = d & (a == 1 ? 8'h03 : a == 2 ? 8'hf8 : 8'hff);
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge clk);
    regRdStb <= 1'b0;
    #1 rv = regRdData_q;
  endtask
  task automatic idle(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // Flags show only while the loop is really running
  function automatic logic [7:0] expRd(input logic [7:0] a);
    if (a == 2 && mdl[2][4] && !mdl[2][3] && !mdl[1][0]) return mdl[2] | {5'h0, dllFlagsPin};
    return mdl[a];
  endfunction
  task automatic chkOut;
    logic [7:0] m1, m2, m3;
    m1 = mdl[1];
    m2 = mdl[2];
    m3 = mdl[3];
    chk("fmt", {5'h0, unsignedInput_q, singlePortInterleave_q, ifaceClkDrive24mA_q},
      {5'h0, m2[7:5]});
    if (!m1[0]) chk("oe", {7'h0, ifaceClkOe_n_q}, {7'h0, !m2[3]});
    if (!m1[0] && !m2[3]) chk("dll", {7'h0, ifaceClkDllOn_q}, {7'h0, m2[4]});
    chk("src", {6'h0, dacSource_q}, {6'h0, m1[1], m1[1] ? m3[6] : m3[7]});
    if (m1[1]) chk("hilb", {7'h0, hilbertOn_q}, {7'h0, m3[5]});
    chk("flt", {3'h0, stageHighpass_q, ifaceClkPolarity_q, iqOrderPolarity_q},
      {3'h0, m3[4:0]});
    chk("pll", {3'h0, clock_multiplier_enable_q, pllMultiply_q, pllDivide_q}, {3'h0, mdl[4][7:3]});
    chk("loc", memLocation_q, mdl[8'h10]);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    foreach (mdl[i]) mdl[i] = 8'h00;
    mdl[8'h0d] = {4'h0, `DICR_REVISION_ID};
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    chk("oerst", {7'h0, ifaceClkOe_n_q}, 8'h1);
    foreach (rs[i]) begin
      rd(rs[i]);
      chk("rst", rv, expRd(rs[i]));
    end
    wr(8'h0d, 8'hff);
    wr(8'h20, 8'hff);
    rd(8'h0d);
    chk("ro", rv, mdl[8'h0d]);
    rd(8'h20);
    chk("unmap", rv, 8'h00);
    $display("reset and map test done");
    for (int i = 0; i < 40; i++) begin
      dllFlagsPin <= 3'($random(seed));
      dataRateTick <= 1'($random(seed));
      wr(ads[i % 5], 8'($random(seed)));
      rd(ads[i % 5]);
      chk("rd", rv, expRd(ads[i % 5]));
      chkOut;
    end
    $display("random register test done");
    for (int k = 0; k < 4; k++) begin
      wr(k == 0 ? 8'h0e : 8'h0f, k == 0 ? 8'h40 : 8'h10 >> k);
      n = 0;
      while (memOpStrobe_q == 4'h0 && n < 9) begin
        @(posedge clk);
        #1;
        n++;
      end
      chk("lat", 8'(n), 8'd2);
      chk("op", {4'h0, memOpStrobe_q}, 8'h1 << k);
      rd(k == 0 ? 8'h0e : 8'h0f);
      chk("pend", rv & 8'h4e, k == 0 ? 8'h40 : 8'h10 >> k);
      memAckPin <= 1'b1;
      idle(2);
      memAckPin <= 1'b0;
      idle(6);
      rd(k == 0 ? 8'h0e : 8'h0f);
      chk("clr", rv & 8'h4e, 8'h00);
    end
    $display("memory operation test done");
    dataRateTick <= 1'b1;
    wr(8'h0e, 8'h01);
    wr(8'h0f, 8'h40);
    idle(1);
    chk("run", {7'h0, calRunning_q}, 8'h1);
    c = calClock_q;
    for (n = 0; calClock_q === c && n < 99; n++) idle(1);
    for (n = 0; calClock_q !== c && n < 99; n++) idle(1);
    chk("calclk", 8'(n), 8'd32);
    calDonePin <= 1'b1;
    masterFusePin <= 1'b1;
    idle(6);
    chk("done", {7'h0, calRunning_q}, 8'h0);
    rd(8'h0f);
    chk("stat", rv & 8'hc0, 8'h80);
    rd(8'h0e);
    chk("fuse", rv & 8'hb0, 8'h90);
    calDonePin <= 1'b0;
    wr(8'h0f, 8'h01);
    idle(1);
    chk("byp", {7'h0, bypassCal_q}, 8'h1);
    rd(8'h0e);
    chk("srcbyp", rv & 8'h30, 8'h00);
    wr(8'h0f, 8'h10);
    idle(1);
    chk("xrun", {7'h0, xferRunning_q}, 8'h1);
    rd(8'h0f);
    chk("xst", rv & 8'h30, 8'h10);
    xferDonePin <= 1'b1;
    idle(6);
    rd(8'h0f);
    chk("xdone", rv & 8'h30, 8'h20);
    chk("xend", {7'h0, xferRunning_q}, 8'h0);
    $display("calibration and transfer test done");
    finish_test;
  end
endmodule
